// ### logic/nip_pkg.sv
// Constants and types for the nested interrupt priority block
`default_nettype none
package nip_pkg;
	localparam int NVEC = 14;
	localparam int NGRP = 4;
	// Vector numbers (hardware order, 0 highest and never masked by level)
	localparam int VEC_TLI = 0;
	localparam int VEC_TIMEBASE = 1;
	localparam int VEC_EXT0 = 2;
	localparam int VEC_EXT1 = 3;
	localparam int VEC_CAN_SC = 7;
	localparam int VEC_SPI = 8;
	localparam int VEC_PWM = 13;
	localparam logic [15:0] VEC_ADDR_TOP = 16'hfffa;
	// Level bit pairs {high, low}
	localparam logic [1:0] LVL0 = 2'b10;
	localparam logic [1:0] LVL1 = 2'b01;
	localparam logic [1:0] LVL2 = 2'b00;
	localparam logic [1:0] LVL3 = 2'b11;
	localparam int CC_HI_BIT = 5;
	localparam int CC_LO_BIT = 3;
	// Sensitivity codes
	localparam logic [1:0] SNS_FALL_LOW = 2'b00;
	localparam logic [1:0] SNS_RISE = 2'b01;
	localparam logic [1:0] SNS_FALL = 2'b10;
	localparam logic [1:0] SNS_BOTH = 2'b11;
	// Register indices, byte address is four times these
	localparam logic [9:0] IDX_PRIO0 = 10'h025;
	localparam logic [9:0] IDX_PRIO1 = 10'h026;
	localparam logic [9:0] IDX_PRIO2 = 10'h027;
	localparam logic [9:0] IDX_PRIO3 = 10'h028;
	localparam logic [9:0] IDX_SENSE = 10'h029;
	localparam logic [9:0] IDX_STAT = 10'h030;
	localparam logic [7:0] PRIO_RST = 8'hff;
	localparam logic [7:0] PRIO3_RO = 8'hf0;
	localparam logic [7:0] SENSE_RST = 8'h00;
	// Status register layout
	localparam int ST_LVL_LSB = 0;
	localparam int ST_REQ_BIT = 2;
	localparam int ST_VEC_LSB = 4;
	localparam int ST_PEND_LSB = 8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic ack;
		logic irq_enable_instr;
		logic sim;
		logic halt;
		logic wait_for_irq_instr;
		logic trap;
		logic irq_return_instr;
		logic popcc;
	} nip_cpu_evt_t;

	typedef struct packed {
		logic        req;
		logic [3:0]  vec;
		logic [15:0] addr;
	} nip_svc_t;
endpackage
`default_nettype wire

// ### logic/nip_ctrl.sv
// Nested interrupt priority, wake and external sensitivity logic
// Behaviour
// R01: Priority registers reset to all ones
// R02: Two-bit field per vector, vector zero lowest
// R03: Fields encoded like current-level pair
// R04: Level-0 pattern write ignored per field
// R05: Reset, trap, top pin set level 3
// R06: Top pin field stored, never arbitrates
// R07: Rewritten field re-enters only if higher
// R08: Enable/wait/halt load 10, disable/trap 11
// R09: Return and pop restore level bits
// R10: Jump flags from level equal 11
// R11: Level instructions act immediately in routines
// R12: Fixed hardware order and vector addresses
// R13: Only listed sources wake from halt
// R14: Shared CAN vector wakes on status change
// R15: Four two-bit sensitivity modes per group
// R16: Sensitivity writes only at level 3
// R17: Changed sensitivity clears group pending
// R18: Sensitivity reset zero, group three top
// R19: Level pair ranking 10<01<00<11
// R20: Highest level first, ties by order
// R21: Groups two..zero in lower bit pairs
// R22: Edges latched, cleared on entry, pins ORed
// R23: Fourth register upper nibble reads ones
// R24: Low level keeps request asserted
`timescale 1ns/10ps
`default_nettype none
module nip_ctrl #(
	parameter int PINS = 2
) (
	// Clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout_r,
	output logic                        hresp_r,
	output logic [31:0]                 hrdata_r,
	// CPU core
	input  wire nip_pkg::nip_cpu_evt_t  cpu_evt,
	input  wire logic [7:0]             pop_flags_instr,
	input  wire logic                   halt_mode,
	input  wire logic                   active_halt,
	output nip_pkg::nip_svc_t           svc_r,
	output logic                        level_bit_high_r,
	output logic                        level_bit_low_r,
	output logic                        jump_if_masked_r,
	output logic                        jump_if_unmasked_r,
	output logic                        wake_r,
	// Request sources
	input  wire logic                   tli_edge,
	input  wire logic [13:1]            periph_req,
	input  wire logic                   can_sc_wake,
	input  wire logic [4*PINS-1:0]      ext_pin
);

	localparam int NVEC = nip_pkg::NVEC;
	initial begin
		if (PINS < 1 || PINS > 8)
			$error("nip_ctrl: PINS out of range");
	end

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Rank of a level pair, 0 lowest
	// R19: level ranking
	function automatic logic [1:0] rank(input logic [1:0] p);
		unique case (p)
			nip_pkg::LVL0: rank = 2'h0;
			nip_pkg::LVL1: rank = 2'h1;
			nip_pkg::LVL2: rank = 2'h2;
			nip_pkg::LVL3: rank = 2'h3;
		endcase
	endfunction

	// Merge one priority byte, keeping fields written with level 0
	function automatic logic [7:0] prio_merge(
		input logic [7:0] old,
		input logic [7:0] wr
	);
		logic [7:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			// R04: level 0 not writable
			if (wr[2*k +: 2] != nip_pkg::LVL0)
				r[2*k +: 2] = wr[2*k +: 2];
		end
		prio_merge = r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]  prio_r [0:3];
	logic [7:0]  sense_r;
	logic [1:0]  level_r;
	logic [1:0]  level_nxt;
	logic [3:0]  ext_pend_r;
	logic        tli_pend_r;
	logic [4*PINS-1:0] pin_prev_r;
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [9:0]  wr_idx_r;
	logic [9:0]  rd_idx_r;
	logic [3:0]  ext_set;
	logic [3:0]  ext_low;
	logic [3:0]  ext_req;
	logic [3:0]  sense_chg;
	logic        sense_we;
	logic [NVEC-1:0] pend_all;
	logic [NVEC-1:0] wake_set;
	logic [NVEC-1:0] cand;
	logic        found;
	logic [3:0]  best_vec;
	logic [1:0]  best_rank;
	logic [1:0]  fields [0:NVEC-1];
	logic [31:0] rd_val;
	logic        accept;

	assign level_bit_high_r = level_r[1];
	assign level_bit_low_r  = level_r[0];

	// R02: field of vector v sits in register v/4, pair v%4
	// R03: fields share the level pair coding
	always_comb begin
		for (int v = 0; v < NVEC; v++)
			fields[v] = prio_r[v / 4][2*(v % 4) +: 2];
	end

	////////////////////////////////////////////////////////////////////
	// Bus slave

	assign accept = hsel && hready && htrans == nip_pkg::HTRANS_NONSEQ;

	// Reads take one wait state so a preceding write is seen
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			wr_idx_r    <= 10'h000;
			rd_idx_r    <= 10'h000;
			hreadyout_r <= 1'b1;
			hresp_r     <= nip_pkg::HRESP_OKAY;
			hrdata_r    <= 32'h0000_0000;
		end else begin
			wr_pend_r <= accept && hwrite;
			if (accept)
				wr_idx_r <= haddr[11:2];
			if (accept && !hwrite) begin
				rd_idx_r    <= haddr[11:2];
				rd_pend_r   <= 1'b1;
				hreadyout_r <= 1'b0;
			end else if (rd_pend_r) begin
				rd_pend_r   <= 1'b0;
				hreadyout_r <= 1'b1;
				hrdata_r    <= rd_val;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (rd_idx_r)
			nip_pkg::IDX_PRIO0: rd_val[7:0] = prio_r[0];
			nip_pkg::IDX_PRIO1: rd_val[7:0] = prio_r[1];
			nip_pkg::IDX_PRIO2: rd_val[7:0] = prio_r[2];
			// R23: upper nibble reads ones
			nip_pkg::IDX_PRIO3:
				rd_val[7:0] = prio_r[3] | nip_pkg::PRIO3_RO;
			nip_pkg::IDX_SENSE: rd_val[7:0] = sense_r;
			nip_pkg::IDX_STAT: begin
				rd_val[nip_pkg::ST_LVL_LSB +: 2] = level_r;
				rd_val[nip_pkg::ST_REQ_BIT] = svc_r.req;
				rd_val[nip_pkg::ST_VEC_LSB +: 4] = svc_r.vec;
				rd_val[nip_pkg::ST_PEND_LSB +: NVEC] = pend_all;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Priority registers

	always_ff @(posedge clock) begin
		if (rst) begin
			// R01: all vectors start at level 3
			for (int i = 0; i < 4; i++)
				prio_r[i] <= nip_pkg::PRIO_RST;
		end else if (wr_pend_r) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_idx_r == nip_pkg::IDX_PRIO0 + 10'(i))
					prio_r[i] <= prio_merge(prio_r[i], hwdata[7:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// External sensitivity

	// R16: writes accepted only at level 3
	assign sense_we = wr_pend_r && wr_idx_r == nip_pkg::IDX_SENSE
		&& level_r == nip_pkg::LVL3;

	always_comb begin
		for (int g = 0; g < 4; g++)
			sense_chg[g] = sense_we
				&& hwdata[2*g +: 2] != sense_r[2*g +: 2];
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			// R18: all groups falling edge and low level
			sense_r <= nip_pkg::SENSE_RST;
		end else if (sense_we) begin
			// R21: group g in bits 2g+1:2g
			sense_r <= hwdata[7:0];
		end
	end

	// Pins idle high, so a pin low at reset gives one falling edge
	always_ff @(posedge clock) begin
		if (rst)
			pin_prev_r <= '1;
		else
			pin_prev_r <= ext_pin;
	end

	always_comb begin
		logic [PINS-1:0] cur;
		logic [PINS-1:0] prv;
		logic rise;
		logic fall;
		cur = '0;
		prv = '0;
		rise = 1'b0;
		fall = 1'b0;
		for (int g = 0; g < 4; g++) begin
			cur = ext_pin[g*PINS +: PINS];
			prv = pin_prev_r[g*PINS +: PINS];
			// R22: pins of one group ORed
			rise = |(cur & ~prv);
			fall = |(~cur & prv);
			ext_low[g] = |(~cur);
			// R15: edge selection per mode
			unique case (sense_r[2*g +: 2])
				nip_pkg::SNS_FALL_LOW: ext_set[g] = fall;
				nip_pkg::SNS_RISE:     ext_set[g] = rise;
				nip_pkg::SNS_FALL:     ext_set[g] = fall;
				nip_pkg::SNS_BOTH:     ext_set[g] = rise | fall;
			endcase
			// R24: low level holds the request
			ext_req[g] = ext_pend_r[g] || (ext_low[g]
				&& sense_r[2*g +: 2] == nip_pkg::SNS_FALL_LOW);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ext_pend_r <= 4'h0;
		end else begin
			for (int g = 0; g < 4; g++) begin
				// R22: cleared on entry, new edge wins
				// R17: changed mode clears pending
				if (ext_set[g])
					ext_pend_r[g] <= 1'b1;
				else if (sense_chg[g] || (cpu_evt.ack
					&& svc_r.vec == 4'(nip_pkg::VEC_EXT0 + g)))
					ext_pend_r[g] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			tli_pend_r <= 1'b0;
		else if (tli_edge)
			tli_pend_r <= 1'b1;
		else if (cpu_evt.ack && svc_r.vec == 4'(nip_pkg::VEC_TLI))
			tli_pend_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Arbitration

	always_comb begin
		pend_all = {periph_req, 1'b0};
		pend_all[nip_pkg::VEC_TLI] = tli_pend_r;
		for (int g = 0; g < 4; g++)
			pend_all[nip_pkg::VEC_EXT0 + g] =
				ext_req[g] | periph_req[nip_pkg::VEC_EXT0 + g];
		// R13: wake-capable sources only
		wake_set = '0;
		wake_set[nip_pkg::VEC_TLI] = tli_pend_r;
		wake_set[nip_pkg::VEC_TIMEBASE] =
			periph_req[nip_pkg::VEC_TIMEBASE] && active_halt;
		wake_set[nip_pkg::VEC_EXT0 +: 4] = ext_req;
		wake_set[nip_pkg::VEC_EXT0] = pend_all[nip_pkg::VEC_EXT0];
		wake_set[nip_pkg::VEC_EXT0 + 2] = pend_all[nip_pkg::VEC_EXT0 + 2];
		wake_set[nip_pkg::VEC_EXT0 + 3] = pend_all[nip_pkg::VEC_EXT0 + 3];
		// R14: shared CAN vector wakes on status change only
		wake_set[nip_pkg::VEC_CAN_SC] =
			periph_req[nip_pkg::VEC_CAN_SC] && can_sc_wake;
		wake_set[nip_pkg::VEC_SPI] = periph_req[nip_pkg::VEC_SPI];
		wake_set[nip_pkg::VEC_PWM] = periph_req[nip_pkg::VEC_PWM];
		cand = halt_mode ? wake_set : pend_all;
	end

	// R20: highest level, ties to lower vector number
	// R12: vector number is the hardware order
	always_comb begin
		logic [1:0] r;
		r = 2'h0;
		found = 1'b0;
		best_vec = 4'h0;
		best_rank = 2'h0;
		for (int v = NVEC - 1; v >= 1; v--) begin
			r = rank(fields[v]);
			if (cand[v] && r > rank(level_r)
				&& (!found || r >= best_rank)) begin
				found = 1'b1;
				best_vec = 4'(v);
				best_rank = r;
			end
		end
		// R06: top pin ignores its field and beats level 3
		if (cand[nip_pkg::VEC_TLI]) begin
			found = 1'b1;
			best_vec = 4'(nip_pkg::VEC_TLI);
		end
	end

	// Request drops for a cycle after an entry so the new level is seen
	always_ff @(posedge clock) begin
		if (rst) begin
			svc_r  <= '0;
			wake_r <= 1'b0;
		end else begin
			svc_r.req <= found && !cpu_evt.ack;
			svc_r.vec <= best_vec;
			svc_r.addr <= nip_pkg::VEC_ADDR_TOP - {11'h000, best_vec, 1'b0};
			wake_r <= halt_mode && found;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Current level

	always_comb begin
		level_nxt = level_r;
		if (cpu_evt.ack) begin
			// R05: top pin entry sets level 3
			// R07: a rewritten field applies only on a new entry
			if (svc_r.vec == 4'(nip_pkg::VEC_TLI))
				level_nxt = nip_pkg::LVL3;
			else
				level_nxt = fields[svc_r.vec];
		end else if (cpu_evt.irq_return_instr || cpu_evt.popcc) begin
			// R09: level restored from popped flags
			level_nxt = {pop_flags_instr[nip_pkg::CC_HI_BIT],
				pop_flags_instr[nip_pkg::CC_LO_BIT]};
		end else if (cpu_evt.sim || cpu_evt.trap) begin
			// R08: disable and trap load 11
			// R11: takes effect at once
			level_nxt = nip_pkg::LVL3;
		end else if (cpu_evt.irq_enable_instr || cpu_evt.wait_for_irq_instr || cpu_evt.halt) begin
			// R08: enable, wait and halt load 10
			level_nxt = nip_pkg::LVL0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			// R05: reset routine runs at level 3
			level_r <= nip_pkg::LVL3;
			jump_if_masked_r <= 1'b1;
			jump_if_unmasked_r <= 1'b0;
		end else begin
			level_r <= level_nxt;
			// R10: jump conditions on level 3
			jump_if_masked_r <= level_nxt == nip_pkg::LVL3;
			jump_if_unmasked_r <= level_nxt != nip_pkg::LVL3;
		end
	end

endmodule
`default_nettype wire

// ### dv/nip_chk.sv
// Checker for the nested interrupt priority block
`timescale 1ns/10ps
`default_nettype none
module nip_chk (
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  rst,
	// CPU side
	input wire nip_pkg::nip_cpu_evt_t cpu_evt,
	input wire logic [7:0]            pop_flags_instr,
	input wire nip_pkg::nip_svc_t     svc_r,
	input wire logic                  level_bit_high_r,
	input wire logic                  level_bit_low_r,
	input wire logic                  jump_if_masked_r,
	input wire logic                  jump_if_unmasked_r
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [1:0] lvl;
	logic [1:0] pc_lvl;
	logic       pop_ev;
	assign lvl = {level_bit_high_r, level_bit_low_r};
	assign pc_lvl = {pop_flags_instr[5], pop_flags_instr[3]};
	// Higher-ranked events win over level instructions in the same cycle
	assign pop_ev = cpu_evt.ack | cpu_evt.irq_return_instr | cpu_evt.popcc;
	////////////////////////////////////////
	a_jump_masked: assert property (jump_if_masked_r == (lvl == 2'b11))
		else $error("masked jump flag wrong");
	a_jump_pair: assert property (jump_if_unmasked_r != jump_if_masked_r)
		else $error("jump flags not complementary");
	a_disable_lvl: assert property ((cpu_evt.sim | cpu_evt.trap) & !pop_ev |=> lvl == 2'b11)
		else $error("disable did not load level 3");
	a_enable_lvl: assert property ((cpu_evt.irq_enable_instr | cpu_evt.wait_for_irq_instr | cpu_evt.halt) & !pop_ev
		& !cpu_evt.sim & !cpu_evt.trap |=> lvl == 2'b10) else $error("enable did not load 10");
	a_pop_level: assert property ((cpu_evt.irq_return_instr | cpu_evt.popcc) & !cpu_evt.ack
		|=> lvl == $past(pc_lvl)) else $error("popped level not restored");
	a_ack_drop: assert property (cpu_evt.ack & svc_r.req |=> !svc_r.req)
		else $error("request held after acknowledge");
	a_vec_addr: assert property (svc_r.req
		|-> svc_r.addr == nip_pkg::VEC_ADDR_TOP - {11'h0, svc_r.vec, 1'b0}) else $error("bad address");
	a_top_level: assert property (cpu_evt.ack & svc_r.req & svc_r.vec == 4'h0
		|=> lvl == 2'b11) else $error("top pin entry not level 3");
	c_ack: cover property (cpu_evt.ack & svc_r.req);
	c_top: cover property (svc_r.req & svc_r.vec == 4'h0);
	c_ret: cover property (cpu_evt.irq_return_instr);
endmodule
bind nip_ctrl nip_chk u_chk (.clock(clock), .rst(rst), .cpu_evt(cpu_evt), .pop_flags_instr(pop_flags_instr),
	.svc_r(svc_r), .level_bit_high_r(level_bit_high_r), .level_bit_low_r(level_bit_low_r),
	.jump_if_masked_r(jump_if_masked_r), .jump_if_unmasked_r(jump_if_unmasked_r));
`default_nettype wire

// ### dv/nip_cpu_model.sv
// CPU core model: instruction pulses, vector acknowledge, CC stack
`timescale 1ns/10ps
`default_nettype none
module nip_cpu_model (
	// Clock
	input  wire logic              clock,
	// From the block; ack_lat from the bench
	input  wire nip_pkg::nip_svc_t svc,
	input  wire logic              lvl_hi,
	input  wire logic              lvl_lo,
	input  wire logic [1:0]        ack_lat,
	// To the block
	output nip_pkg::nip_cpu_evt_t  evt,
	output logic [7:0]             cc
);
	logic [7:0] stk [$];
	logic [7:0] pend;
	logic [7:0] nv;
	logic [7:0] nx;
	int         w;
	initial begin
		evt = '0;
		cc = 8'h00;
		pend = 8'h00;
		w = 0;
	end
	always @(posedge clock) begin
		nx = 8'h00;
		if (pend != 8'h00) begin
			nx = pend;
			cc <= (pend[1] && stk.size() > 0) ? stk.pop_back() : nv;
			pend = 8'h00;
		end else begin
			// Popped byte is only valid with its pulse
			cc <= ~cc;
			w = (ack_lat != 2'd0 && svc.req && !evt.ack) ? w + 1 : 0;
			if (w != 0 && w >= ack_lat) begin
				nx = 8'h80;
				stk.push_back({2'b11, lvl_hi, 1'b0, lvl_lo, 3'b000});
				w = 0;
			end
		end
		evt <= nx;
	end
	task automatic exec(input logic [7:0] ev, input logic [7:0] v);
		nv = v;
		pend = ev;
		wait (pend == 8'h00);
		@(posedge clock);
		@(negedge clock);
	endtask
endmodule
`default_nettype wire

// ### dv/nip_ctrl_test.sv
// Self-checking bench for the nested interrupt block
`timescale 1ns/10ps
`default_nettype none
module nip_ctrl_test;
	logic                  clock, rst, hsel, hwrite, hready, hresp, tli_edge, halt_mode;
	logic                  lh, ll, jm, ju, wake, active_halt, can_sc_wake;
	logic [1:0]            htrans, lat;
	logic [7:0]            cc, pin;
	logic [13:1]           preq;
	logic [31:0]           haddr, hwdata, hrdata, q;
	nip_pkg::nip_cpu_evt_t evt;
	nip_pkg::nip_svc_t     svc;
	int                    n_mismatch, cmp_count, cyc;
	logic [7:0]            ops [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
	logic [1:0]            lx [5] = '{2'b10, 2'b11, 2'b10, 2'b10, 2'b11};
	nip_ctrl #(.PINS(2)) DUT (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout_r(hready), .hresp_r(hresp), .hrdata_r(hrdata), .cpu_evt(evt), .pop_flags_instr(cc),
		.halt_mode(halt_mode), .active_halt(active_halt), .svc_r(svc), .level_bit_high_r(lh),
		.level_bit_low_r(ll), .jump_if_masked_r(jm), .jump_if_unmasked_r(ju), .wake_r(wake),
		.tli_edge(tli_edge), .periph_req(preq), .can_sc_wake(can_sc_wake), .ext_pin(pin));
	nip_cpu_model u_cpu (.clock(clock), .svc(svc), .lvl_hi(lh), .lvl_lo(ll), .ack_lat(lat),
		.evt(evt), .cc(cc));
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			conclude();
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] adr(input logic [9:0] i);
		return {20'h0, i, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= nip_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic rd(input logic [9:0] i, input logic [31:0] m, input logic [31:0] e);
		bus(adr(i), 1'b0, 32'h0);
		chk(q & m, e);
	endtask
	task automatic lv(input logic [1:0] e);
		chk({28'h0, lh, ll, jm, ju}, {28'h0, e, e == 2'b11, e != 2'b11});
	endtask
	task automatic conclude;
		$display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		clock = 0; rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; q = 0;
		halt_mode = 0; active_halt = 0; tli_edge = 0; can_sc_wake = 0; preq = 0; pin = 8'hff;
		lat = 0; n_mismatch = 0; cmp_count = 0; cyc = 0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) rd(nip_pkg::IDX_PRIO0 + 10'(i), 32'hffffffff, 32'hff);
		rd(nip_pkg::IDX_SENSE, 32'hffffffff, 32'h00);
		rd(10'h100, 32'hffffffff, 32'h0);
		lv(2'b11);
		bus(adr(nip_pkg::IDX_PRIO1), 1'b1, 32'hcf);
		bus(adr(nip_pkg::IDX_PRIO1), 1'b1, 32'h64);
		rd(nip_pkg::IDX_PRIO1, 32'hff, 32'h44);
		bus(adr(nip_pkg::IDX_PRIO3), 1'b1, 32'h00);
		rd(nip_pkg::IDX_PRIO3, 32'hff, 32'hf0);
		bus(adr(nip_pkg::IDX_SENSE), 1'b1, 32'h1b);
		rd(nip_pkg::IDX_SENSE, 32'hff, 32'h1b);
		for (int i = 0; i < 5; i++) begin
			u_cpu.exec(ops[i], 8'h00);
			lv(lx[i]);
			if (i == 0) bus(adr(nip_pkg::IDX_SENSE), 1'b1, 32'hff);
			if (i == 0) rd(nip_pkg::IDX_SENSE, 32'hff, 32'h1b);
		end
		u_cpu.exec(8'h01, 8'h08);
		lv(2'b01);
		u_cpu.exec(8'h01, 8'h20);
		lv(2'b10);
		// Two same-level requests, then one lowered below the other
		bus(adr(nip_pkg::IDX_PRIO2), 1'b1, 32'hf0);
		preq <= 13'h180;
		repeat (3) @(negedge clock);
		chk(svc, {11'h0, 1'b1, 4'd8, 16'hffea});
		bus(adr(nip_pkg::IDX_PRIO2), 1'b1, 32'hf1);
		repeat (2) @(negedge clock);
		chk(svc, {11'h0, 1'b1, 4'd9, 16'hffe8});
		halt_mode <= 1'b1;
		repeat (2) @(negedge clock);
		chk({wake, svc}, {10'h0, 2'b11, 4'd8, 16'hffea});
		halt_mode <= 1'b0;
		lat <= 2'd2;
		repeat (8) @(negedge clock);
		lv(2'b00);
		chk(svc[20], 32'h0);
		lat <= 2'd0;
		u_cpu.exec(8'h02, 8'h00);
		lv(2'b10);
		preq <= 13'h0;
		u_cpu.exec(8'h20, 8'h00);
		@(posedge clock);
		tli_edge <= 1'b1;
		@(posedge clock);
		tli_edge <= 1'b0;
		repeat (2) @(negedge clock);
		chk(svc, {11'h0, 1'b1, 4'd0, 16'hfffa});
		lat <= 2'd1;
		repeat (6) @(negedge clock);
		lv(2'b11);
		chk(svc[20], 32'h0);
		lat <= 2'd0;
		bus(adr(nip_pkg::IDX_SENSE), 1'b1, 32'h02);
		pin <= 8'hfe;
		repeat (3) @(negedge clock);
		rd(nip_pkg::IDX_STAT, 32'h400, 32'h400);
		bus(adr(nip_pkg::IDX_SENSE), 1'b1, 32'h01);
		rd(nip_pkg::IDX_STAT, 32'h400, 32'h0);
		bus(adr(nip_pkg::IDX_SENSE), 1'b1, 32'h00);
		u_cpu.exec(8'h40, 8'h00);
		repeat (3) @(negedge clock);
		chk(svc, {11'h0, 1'b1, 4'd2, 16'hfff6});
		pin <= 8'hff;
		conclude();
	end
endmodule
`default_nettype wire
